// ===== verif/tb_top.sv
// Bench for the UART status and control block
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin fails++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
    import uscp_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, s_in, s_out, s_oe, rx_event, got_stb;
    logic [7:0] awaddr, araddr, d, c;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, nb;
    logic [1:0] bresp, rresp;
    logic [9:0] got_word, last, e_b, e_t, x;
    logic [9:0] bus_q[$], tx_q[$];
    logic [7:0] cfg[4] = '{8'h80, 8'hC1, 8'hA0, 8'hB8};
    int fails = 0, comparisons = 0, events = 0, lo;
    uscp_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .serial_in_pin(s_in), .serial_out_pin(s_out), .serial_out_oe(s_oe),
        .rx_event(rx_event));
    uscp_serial_dev #(.BT(16)) u_dev (.aclk(aclk), .serial_out_pin(s_out),
        .serial_out_oe(s_oe), .nbits(nb), .serial_in_pin(s_in), .got_word(got_word),
        .got_stb(got_stb));
    task automatic summarize();
        $display("Totals: comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tmo();
        fails++;
        summarize();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v,
        input logic [1:0] r = RESP_OKAY, input bit chk = 1'b1);
        int i;
        if (chk) bus_q.push_back({r, 8'h00});
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        @(posedge aclk);
        if (i == 20) tmo();
    endtask
    task automatic rd(input logic [7:0] a, input logic [9:0] v, input bit chk);
        int i;
        if (chk) bus_q.push_back(v);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        last = {rresp, rdata[7:0]};
        rready <= 1'b0;
        @(posedge aclk);
        if (i == 20) tmo();
    endtask
    // Polling reads note no expectation, so the watcher skips them
    task automatic wait_rx();
        int i;
        for (i = 0; i < 20; i++) begin
            rd(OFF_STATUS, 10'h000, 1'b0);
            if (last[ST_RXIF]) break;
        end
        if (i == 20) tmo();
    endtask
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (rx_event === 1'b1) events <= events + 1;
        if (bus_q.size() > 0 && ((rvalid && rready) || (bvalid && bready))) begin
            e_b = bus_q.pop_front();
            `CHK("bus", e_b, rvalid ? {rresp, rdata[7:0]} : {bresp, 8'h00})
        end
        if (got_stb === 1'b1) begin
            e_t = (tx_q.size() > 0) ? tx_q.pop_front() : 10'h3FF;
            `CHK("tx_word", e_t, got_word)
        end
    end
    initial begin
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        nb = 4'h8;
        void'($urandom(32'h7B17));
        tick(2);
        aresetn <= 1'b1;
        tick(1);
        rd(OFF_STATUS, ST_RST, 1'b1);
        wr(OFF_STATUS, 8'hF4);
        rd(OFF_STATUS, ST_RST, 1'b1);
        wr(OFF_CTRL1, 8'h03);
        rd(OFF_CTRL1, 8'h00, 1'b1);
        wr(8'h14, 8'h5A, RESP_SLVERR);
        rd(8'h14, {RESP_SLVERR, 8'h00}, 1'b1);
        // A write with its low strobe off must leave the register alone
        wstrb <= 4'h0;
        wr(OFF_BAUD, 8'h5A);
        wstrb <= 4'hF;
        rd(OFF_BAUD, 8'h00, 1'b1);
        wr(OFF_BAUD, 8'h00);
        wr(OFF_CTRL1, 8'h80);
        wr(OFF_CTRL2, 8'hE4);
        rd(OFF_STATUS, ST_RST, 1'b1);
        foreach (cfg[k]) begin
            c = cfg[k];
            d = 8'($urandom);
            x = {2'b00, d};
            x[8] = c[CR1_LEN9] & c[CR1_TX8];
            x[8 + c[CR1_LEN9]] = c[CR1_PAREN] & (^x[8:0] ^ c[CR1_ODD]);
            nb <= 4'(8 + c[CR1_LEN9] + c[CR1_PAREN]);
            wr(OFF_CTRL1, c);
            rd(OFF_STATUS, 10'h000, 1'b0);
            tx_q.push_back(x);
            wr(OFF_DATA, d);
            rd(OFF_STATUS, 8'h09, 1'b1);
            for (lo = 0; lo < 400 && tx_q.size() > 0; lo++) tick(1);
            if (tx_q.size() > 0) tmo();
            // Between the end of the first stop bit and the end of the second
            tick(12);
            rd(OFF_STATUS, c[CR1_STOP2] ? 8'h09 : ST_RST, 1'b1);
            tick(24);
            rd(OFF_STATUS, ST_RST, 1'b1);
        end
        wr(OFF_CTRL1, 8'hA0);
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            fork
                u_dev.send({1'b0, (^d) ^ (k == 1), d}, 9, k != 2, k == 3);
                begin
                    tick(40);
                    rd(OFF_STATUS, 8'h03, 1'b1);
                end
            join
            wait_rx();
            c = k == 1 ? 8'h8F : k == 2 ? 8'h2F : k == 3 ? 8'h4F : 8'h0F;
            rd(OFF_STATUS, c, 1'b1);
            rd(OFF_DATA, d, 1'b1);
            rd(OFF_STATUS, ST_RST, 1'b1);
        end
        wr(OFF_CTRL1, 8'h80);
        d = 8'($urandom);
        u_dev.send({2'b00, d}, 8, 1'b1);
        u_dev.send(10'h0C3, 8, 1'b1);
        wait_rx();
        rd(OFF_STATUS, 8'h1F, 1'b1);
        rd(OFF_DATA, d, 1'b1);
        rd(OFF_STATUS, ST_RST, 1'b1);
        wr(OFF_CTRL1, 8'hC0);
        u_dev.send({2'b01, d}, 9, 1'b1);
        wait_rx();
        rd(OFF_CTRL1, 8'hC2, 1'b1);
        rd(OFF_DATA, d, 1'b1);
        `CHK("rx_events", 6, events)
        wr(OFF_CTRL1, 8'h84);
        tick(20);
        lo = 0;
        repeat (208) begin
            @(posedge aclk);
            lo += (s_out === 1'b0);
        end
        `CHK("break_low", 208, lo)
        wr(OFF_CTRL1, 8'h80);
        tick(40);
        `CHK("break_end", 1'b1, s_out)
        wr(OFF_DATA, 8'h55);
        tick(60);
        wr(OFF_CTRL1, 8'h00);
        tick(2);
        `CHK("oe_off", 1'b0, s_oe)
        rd(OFF_STATUS, ST_RST, 1'b1);
        rd(OFF_CTRL2, 8'h24, 1'b1);
        tick(200);
        nb <= 4'h8;
        wr(OFF_CTRL1, 8'h80);
        wr(OFF_CTRL2, 8'hE4);
        tx_q.push_back(10'h0A7);
        wr(OFF_DATA, 8'hA7);
        tick(300);
        `CHK("tx_left", 0, tx_q.size())
        summarize();
    end
endmodule // tb_top

// ===== verif/uscp_serial_dev.sv
// Far-side serial device: frame sender and transmit-line decoder
`timescale 1ns/10ps
module uscp_serial_dev #(
    parameter int BT = 16
) (
    // Clock
    input wire logic aclk,
    // Line from the block and frame length to decode
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    input wire logic [3:0] nbits,
    // Line to the block and decoded words
    output logic serial_in_pin,
    output logic [9:0] got_word,
    output logic got_stb
);
    logic line;
    // A released pin is pulled high, so floating never looks like a start bit
    assign line = serial_out_oe ? serial_out_pin : 1'b1;
    initial begin
        serial_in_pin = 1'b1;
        got_stb = 1'b0;
        got_word = '0;
    end
    // Start, data LSB first, stop; a low stop makes a framing fault
    // A noisy frame flips bit 0 for the one cycle before the receiver samples it
    task automatic send(input logic [9:0] w, input int nb, input logic stop,
        input bit nz = 1'b0);
        for (int i = -1; i <= nb; i++) begin
            serial_in_pin <= (i < 0) ? 1'b0 : (i == nb) ? stop : w[i];
            if (nz && i == 0) begin
                repeat (BT / 2 - 1) @(posedge aclk);
                serial_in_pin <= ~w[0];
                @(posedge aclk);
                serial_in_pin <= w[0];
                repeat (BT / 2) @(posedge aclk);
            end else begin
                repeat (BT) @(posedge aclk);
            end
        end
        serial_in_pin <= 1'b1;
        repeat (BT) @(posedge aclk);
    endtask
    always begin
        logic [9:0] w;
        @(posedge aclk);
        if (!line) begin
            w = '0;
            repeat (BT / 2) @(posedge aclk);
            for (int i = 0; i < nbits; i++) begin
                repeat (BT) @(posedge aclk);
                w[i] = line;
            end
            repeat (BT) @(posedge aclk);
            got_word <= w;
            got_stb <= line & serial_out_oe;
            @(posedge aclk);
            got_stb <= 1'b0;
            // A break holds the line low; re-arm only once it is high again
            while (!line) @(posedge aclk);
        end
    end
endmodule // uscp_serial_dev

// ===== verilog/uscp_pkg.sv
// Package of constants and types for the UART status and control block
package uscp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_CTRL2 = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0C;
    localparam logic [7:0] OFF_BAUD = 8'h10;
    // Status field positions
    localparam int ST_PERR = 7;
    localparam int ST_NF = 6;
    localparam int ST_FERR = 5;
    localparam int ST_OERR = 4;
    localparam int ST_RIDLE = 3;
    localparam int ST_RXIF = 2;
    localparam int ST_TIDLE = 1;
    localparam int ST_TXIF = 0;
    // Control one field positions
    localparam int CR1_PEN = 7;
    localparam int CR1_LEN9 = 6;
    localparam int CR1_PAREN = 5;
    localparam int CR1_ODD = 4;
    localparam int CR1_STOP2 = 3;
    localparam int CR1_BRK = 2;
    localparam int CR1_RX8 = 1;
    localparam int CR1_TX8 = 0;
    // Control two field positions
    localparam int CR2_TXEN = 7;
    localparam int CR2_RXEN = 6;
    localparam int CR2_BRGH = 5;
    localparam int CR2_RIE = 2;
    // Reset values and masks
    localparam logic [7:0] ST_RST = 8'h0B;
    localparam logic [7:0] ERR_MASK = 8'hF0;
    localparam logic [7:0] RXA_MASK = 8'h04;
    localparam logic [7:0] TXS_MASK = 8'h03;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing in bit times and clocks per bit
    localparam logic [3:0] BRK_BITS = 4'hD;
    localparam logic [6:0] MUL_LO = 7'h40;
    localparam logic [6:0] MUL_HI = 7'h10;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} uscp_tx_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uscp_rx_t;

    typedef struct packed {
        logic awg, wg, wst, awready, wready, bvalid, arready, rvalid;
        logic [1:0] bresp, rresp;
        logic [7:0] awa, wd, rdata;
        logic [7:0] status, seen, ctrl1, ctrl2, baud, rx_data;
        logic [8:0] tx_hold, tx_sh, rx_sh;
        logic tx_full, tx_par, tx_line, tx_oe, rx_prev, rx_noise, rx_perr, rx_irq;
        uscp_tx_t txs;
        uscp_rx_t rxs;
        logic [13:0] tx_cnt, rx_cnt;
        logic [3:0] tx_idx, rx_idx, brk_n;
    } uscp_state_t;
endpackage

// ===== verilog/uscp_top.sv
// UART status flags, primary control, frame engines and AXI4-Lite registers
// Overview of operation
// - Status flags read-only, reset to 0x0B
// - Parity mismatch sets bit 7, cleared by sequence
// - Noise sets bit 6 with receive-available, not overrun
// - Framing error sets bit 5, cleared by sequence
// - Overrun sets bit 4, blocks further transfers
// - Receiver-idle low from start to stop
// - Word transfer sets bit 2, errors, interrupt
// - Receive-available clears after status then data read
// - Transmitter-idle when empty, nothing sending, line high
// - Transmitter-idle clears by status read, data write
// - Transmit-empty sets on shifter load, clears by sequence
// - Enabling transmitter sets transmit-empty
// - Port enable low floats the serial output pin
// - Disable empties buffer, resets baud counters
// - Disable clears enables, break, flags; sets idles
// - Disable aborts transfers; re-enable keeps configuration
// - Bit 6 selects eight or nine data bits
// - Bit 5 enables parity generation and checking
// - Bit 4 selects even or odd parity
// - Bit 3 selects one or two stop bits
// - Break after buffered data, low thirteen bits minimum
// - Ninth received bit read-only, ninth transmit write-only
// - Data bits shifted least significant first
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
module uscp_top
    import uscp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Serial pins
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    // Receive event when receiver interrupts are enabled
    output logic rx_event
);

    uscp_state_t s_r;
    uscp_state_t s_nxt;
    logic [13:0] per;
    logic len9;
    logic [3:0] last_idx;
    logic [8:0] rx_word;

    // Cycles per bit minus one; max 64 * 256 - 1 fits 14 bits
    function automatic logic [13:0] bit_per(input logic [7:0] b, input logic hi);
        logic [14:0] p;
        p = 15'((hi ? MUL_HI : MUL_LO) * ({7'h00, b} + 15'h1));
        return 14'(p - 15'h1);
    endfunction

    function automatic logic par_bit(input logic [8:0] d, input logic l9, input logic odd);
        return ^{d[8] & l9, d[7:0]} ^ odd;
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a == ADDR_W'(OFF_STATUS) || a == ADDR_W'(OFF_CTRL1) ||
            a == ADDR_W'(OFF_CTRL2) || a == ADDR_W'(OFF_DATA) || a == ADDR_W'(OFF_BAUD);
    endfunction

    assign per = bit_per(s_r.baud, s_r.ctrl2[CR2_BRGH]);
    assign len9 = s_r.ctrl1[CR1_LEN9];
    assign last_idx = len9 ? 4'h8 : 4'h7;
    assign rx_word = len9 ? s_r.rx_sh : {1'b0, s_r.rx_sh[8:1]};

    always_comb begin
        logic dw;
        dw = 1'b0;
        s_nxt = s_r;
        s_nxt.rx_irq = 1'b0;
        // Write address and data are taken in either order
        if (awvalid && s_r.awready) begin
            s_nxt.awg = 1'b1;
            s_nxt.awa = awaddr[7:0];
        end
        if (wvalid && s_r.wready) begin
            s_nxt.wg = 1'b1;
            s_nxt.wd = wdata[7:0];
            s_nxt.wst = wstrb[0];
        end
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_nxt.awg && s_nxt.wg && !s_r.bvalid) begin
            s_nxt.awg = 1'b0;
            s_nxt.wg = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = is_mapped(ADDR_W'(s_nxt.awa)) ? RESP_OKAY : RESP_SLVERR;
            if (s_nxt.wst) begin
                case (s_nxt.awa)
                    OFF_CTRL1: begin
                        s_nxt.ctrl1 = {s_nxt.wd[7:2], s_r.ctrl1[CR1_RX8], s_nxt.wd[0]};
                    end
                    OFF_CTRL2: begin
                        if (s_nxt.wd[CR2_TXEN] && !s_r.ctrl2[CR2_TXEN]) begin
                            s_nxt.status[ST_TXIF] = 1'b1;
                        end
                        s_nxt.ctrl2 = s_nxt.wd;
                    end
                    OFF_DATA: begin
                        dw = 1'b1;
                        s_nxt.tx_hold = {s_r.ctrl1[CR1_TX8], s_nxt.wd};
                        s_nxt.tx_full = 1'b1;
                        s_nxt.status = s_nxt.status & ~(s_r.seen & (TXS_MASK | ERR_MASK));
                        s_nxt.seen = 8'h00;
                    end
                    OFF_BAUD: begin
                        s_nxt.baud = s_nxt.wd;
                    end
                    default: begin
                        // Status is read-only; writes are dropped
                    end
                endcase
            end
        end
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            s_nxt.rdata = 8'h00;
            case (araddr[7:0])
                OFF_STATUS: begin
                    s_nxt.rdata = s_r.status;
                    s_nxt.seen = s_r.status;
                end
                OFF_CTRL1: begin
                    s_nxt.rdata = {s_r.ctrl1[7:1], 1'b0};
                end
                OFF_CTRL2: begin
                    s_nxt.rdata = s_r.ctrl2;
                end
                OFF_DATA: begin
                    s_nxt.rdata = s_r.rx_data;
                    // Single holding register; a read empties it only if status was read first
                    s_nxt.status = s_nxt.status & ~(s_r.seen & (RXA_MASK | ERR_MASK));
                    s_nxt.seen = 8'h00;
                end
                OFF_BAUD: begin
                    s_nxt.rdata = s_r.baud;
                end
                default: begin
                    s_nxt.rdata = 8'h00;
                end
            endcase
        end

        // Transmit engine runs after the bus so its flag sets win
        if (s_r.txs != TX_IDLE && s_r.tx_cnt != 14'h0) begin
            s_nxt.tx_cnt = 14'(s_r.tx_cnt - 14'h1);
        end else begin
            unique case (s_r.txs)
                TX_IDLE: begin
                    s_nxt.tx_line = 1'b1;
                    if (s_r.tx_full && s_r.ctrl2[CR2_TXEN]) begin
                        s_nxt.tx_sh = s_r.tx_hold;
                        s_nxt.tx_par = par_bit(s_r.tx_hold, len9, s_r.ctrl1[CR1_ODD]);
                        s_nxt.tx_full = dw;
                        s_nxt.status[ST_TXIF] = 1'b1;
                        s_nxt.txs = TX_START;
                        s_nxt.tx_cnt = per;
                        s_nxt.tx_line = 1'b0;
                    end else if (s_r.ctrl1[CR1_BRK] && s_r.ctrl2[CR2_TXEN]) begin
                        // Queued data always goes before the break
                        s_nxt.txs = TX_BRK;
                        s_nxt.brk_n = 4'h0;
                        s_nxt.tx_cnt = per;
                        s_nxt.tx_line = 1'b0;
                    end
                end
                TX_START: begin
                    s_nxt.txs = TX_DATA;
                    s_nxt.tx_idx = 4'h0;
                    s_nxt.tx_cnt = per;
                    s_nxt.tx_line = s_r.tx_sh[0];
                end
                TX_DATA: begin
                    s_nxt.tx_cnt = per;
                    s_nxt.tx_idx = 4'(s_r.tx_idx + 4'h1);
                    s_nxt.tx_sh = s_r.tx_sh >> 1;
                    s_nxt.tx_line = s_r.tx_sh[1];
                    if (s_r.tx_idx == last_idx) begin
                        s_nxt.tx_idx = 4'h0;
                        s_nxt.txs = s_r.ctrl1[CR1_PAREN] ? TX_PAR : TX_STOP;
                        s_nxt.tx_line = s_r.ctrl1[CR1_PAREN] ? s_r.tx_par : 1'b1;
                    end
                end
                TX_PAR: begin
                    s_nxt.txs = TX_STOP;
                    s_nxt.tx_cnt = per;
                    s_nxt.tx_line = 1'b1;
                end
                TX_STOP: begin
                    s_nxt.tx_cnt = per;
                    if (s_r.ctrl1[CR1_STOP2] && s_r.tx_idx == 4'h0) begin
                        s_nxt.tx_idx = 4'h1;
                    end else begin
                        s_nxt.txs = TX_IDLE;
                    end
                end
                TX_BRK: begin
                    s_nxt.tx_cnt = per;
                    if (s_r.brk_n != 4'(BRK_BITS - 4'h1)) begin
                        s_nxt.brk_n = 4'(s_r.brk_n + 4'h1);
                    end else if (!s_r.ctrl1[CR1_BRK]) begin
                        s_nxt.txs = TX_IDLE;
                        s_nxt.tx_line = 1'b1;
                    end
                end
            endcase
        end
        if (!s_r.ctrl2[CR2_TXEN]) begin
            s_nxt.txs = TX_IDLE;
            s_nxt.tx_line = 1'b1;
        end
        if (s_nxt.status[ST_TXIF] && s_nxt.txs == TX_IDLE && !s_nxt.tx_full &&
            !s_r.ctrl1[CR1_BRK]) begin
            s_nxt.status[ST_TIDLE] = 1'b1;
        end

        // Receive engine; a one-cycle change around the sample point counts as noise
        s_nxt.rx_prev = serial_in_pin;
        if (s_r.rxs == RX_IDLE) begin
            if (s_r.ctrl2[CR2_RXEN] && !serial_in_pin) begin
                s_nxt.rxs = RX_START;
                s_nxt.rx_cnt = per >> 1;
                s_nxt.rx_noise = 1'b0;
                s_nxt.rx_perr = 1'b0;
                s_nxt.status[ST_RIDLE] = 1'b0;
            end
        end else if (s_r.rx_cnt != 14'h0) begin
            s_nxt.rx_cnt = 14'(s_r.rx_cnt - 14'h1);
        end else begin
            s_nxt.rx_cnt = per;
            if (serial_in_pin != s_r.rx_prev) begin
                s_nxt.rx_noise = 1'b1;
            end
            unique case (s_r.rxs)
                RX_START: begin
                    // A start bit gone high by mid-bit was a glitch
                    s_nxt.rxs = serial_in_pin ? RX_IDLE : RX_DATA;
                    s_nxt.status[ST_RIDLE] = serial_in_pin;
                    s_nxt.rx_idx = 4'h0;
                end
                RX_DATA: begin
                    s_nxt.rx_sh = {serial_in_pin, s_r.rx_sh[8:1]};
                    s_nxt.rx_idx = 4'(s_r.rx_idx + 4'h1);
                    if (s_r.rx_idx == last_idx) begin
                        s_nxt.rxs = s_r.ctrl1[CR1_PAREN] ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: begin
                    s_nxt.rx_perr = serial_in_pin !=
                        par_bit(rx_word, len9, s_r.ctrl1[CR1_ODD]);
                    s_nxt.rxs = RX_STOP;
                end
                RX_STOP: begin
                    s_nxt.rxs = RX_IDLE;
                    s_nxt.status[ST_RIDLE] = 1'b1;
                    if (s_nxt.status[ST_OERR] || s_nxt.status[ST_RXIF]) begin
                        s_nxt.status[ST_OERR] = 1'b1;
                    end else begin
                        s_nxt.rx_data = rx_word[7:0];
                        s_nxt.ctrl1[CR1_RX8] = rx_word[8];
                        s_nxt.status[ST_RXIF] = 1'b1;
                        s_nxt.status[ST_NF] = s_nxt.status[ST_NF] | s_nxt.rx_noise;
                        s_nxt.status[ST_FERR] = s_nxt.status[ST_FERR] | !serial_in_pin;
                        s_nxt.status[ST_PERR] = s_nxt.status[ST_PERR] |
                            (s_nxt.rx_perr & s_r.ctrl1[CR1_PAREN]);
                        s_nxt.rx_irq = s_r.ctrl2[CR2_RIE];
                    end
                end
                default: begin
                    s_nxt.rxs = RX_IDLE;
                end
            endcase
        end
        if (!s_r.ctrl2[CR2_RXEN]) begin
            s_nxt.rxs = RX_IDLE;
            s_nxt.status[ST_RIDLE] = 1'b1;
        end

        // Port disable overrides all; other settings survive for re-enable
        if (!s_r.ctrl1[CR1_PEN]) begin
            s_nxt.ctrl2[CR2_TXEN] = 1'b0;
            s_nxt.ctrl2[CR2_RXEN] = 1'b0;
            s_nxt.ctrl1[CR1_BRK] = 1'b0;
            s_nxt.status = ST_RST;
            s_nxt.seen = 8'h00;
            s_nxt.tx_full = 1'b0;
            s_nxt.tx_cnt = 14'h0;
            s_nxt.rx_cnt = 14'h0;
            s_nxt.txs = TX_IDLE;
            s_nxt.rxs = RX_IDLE;
            s_nxt.tx_line = 1'b1;
            s_nxt.rx_irq = 1'b0;
        end
        s_nxt.tx_oe = s_nxt.ctrl1[CR1_PEN] & s_nxt.ctrl2[CR2_TXEN];
        s_nxt.awready = !s_nxt.awg && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.wg && !s_nxt.bvalid;
        s_nxt.arready = !s_nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.status <= ST_RST;
            s_r.tx_line <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign awready = s_r.awready;
    assign wready = s_r.wready;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign arready = s_r.arready;
    assign rvalid = s_r.rvalid;
    assign rresp = s_r.rresp;
    assign rdata = {24'h000000, s_r.rdata};
    assign serial_out_pin = s_r.tx_line;
    assign serial_out_oe = s_r.tx_oe;
    assign rx_event = s_r.rx_irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence brk_entered;
        s_r.txs == TX_BRK && s_r.brk_n == 4'h0;
    endsequence
    sequence word_done;
        $rose(s_r.status[ST_RXIF]);
    endsequence

    chk_reset_flags: assert property ($rose(aresetn) |-> s_r.status == ST_RST)
        else $error("status reset value wrong");
    chk_perr_needs_par: assert property ($rose(s_r.status[ST_PERR]) |-> $past(s_r.ctrl1[CR1_PAREN]))
        else $error("parity error without parity enabled");
    chk_noise_with_word: assert property ($rose(s_r.status[ST_NF]) |-> word_done)
        else $error("noise flag set apart from receive-available");
    chk_overrun_holds: assert property (s_r.status[ST_OERR] && $past(s_r.status[ST_OERR])
        |-> $stable(s_r.rx_data))
        else $error("data moved during overrun");
    chk_rx_busy_flag: assert property (s_r.rxs != RX_IDLE |-> !s_r.status[ST_RIDLE])
        else $error("receiver idle flag set mid-frame");
    chk_word_event: assert property (word_done |-> s_r.rx_irq == $past(s_r.ctrl2[CR2_RIE]))
        else $error("receive event does not follow enable");
    chk_idle_line_high: assert property (s_r.status[ST_TIDLE] && s_r.txs == TX_IDLE
        |-> s_r.tx_line)
        else $error("line low while transmitter idle");
    chk_txen_sets_empty: assert property ($rose(s_r.ctrl2[CR2_TXEN]) |-> s_r.status[ST_TXIF])
        else $error("transmit-empty not set on enable");
    chk_pins_float: assert property (!s_r.ctrl1[CR1_PEN] |=> !serial_out_oe)
        else $error("serial pin driven while disabled");
    chk_disable_state: assert property ($fell(s_r.ctrl1[CR1_PEN]) |=> s_r.status == ST_RST
        && !s_r.ctrl2[CR2_TXEN] && !s_r.ctrl2[CR2_RXEN] && !s_r.ctrl1[CR1_BRK])
        else $error("disable did not reset flags");
    chk_break_low: assert property (brk_entered ##1 s_r.ctrl1[CR1_PEN] && s_r.ctrl2[CR2_TXEN]
        |-> s_r.txs == TX_BRK && !s_r.tx_line)
        else $error("break ended early");
    chk_break_min: assert property (s_r.txs == TX_BRK && s_r.brk_n != 4'hC && s_r.ctrl1[CR1_PEN]
        && s_r.ctrl2[CR2_TXEN] |=> s_r.txs == TX_BRK)
        else $error("break shorter than thirteen bit times");
    chk_lsb_first: assert property (s_r.txs == TX_START && s_r.tx_cnt == 14'h0 && s_r.ctrl2[CR2_TXEN]
        && s_r.ctrl1[CR1_PEN] |=> s_r.tx_line == $past(s_r.tx_sh[0]))
        else $error("first data bit is not the lowest");

endmodule // uscp_top
